// *** rtl/pml_regs.svh ***
/*
  constants of the program memory lock block: lock byte layout, signature
  defaults, code span, lock bit polarity and reset value. assumes inclusion by bare name.
*/
`ifndef PML_REGS_SVH
`define PML_REGS_SVH

// lock byte in a submitted image and its bit positions
`define PML_LOCK_BYTE_ADDR  16'h8020
`define PML_LOCK_FIRST_POS  0
`define PML_LOCK_SECOND_POS 1
`define PML_LOCK_THIRD_POS  3
// user code image span
`define PML_CODE_LAST_ADDR  16'h7fff
// lock bit value: zero enables the protection
`define PML_LOCK_ACTIVE     1'b0
// signature bytes, values arbitrary
`define PML_SIG_BYTE0       8'h5a
`define PML_SIG_BYTE1       8'ha5
`define PML_SIG_BYTE2       8'h3c
// reset value of latched lock bits: all unprogrammed
`define PML_LOCK_RESET      3'h7

`endif

// *** rtl/pml_pkg.sv ***
/*
  types of the program memory lock block.
  assumes pml_regs.svh for numeric constants.
*/
package pml_pkg;
  // protection level, one-hot
  typedef enum logic [4:0] {
    PML_LVL_NONE  = 5'b00001,
    PML_LVL_ONE   = 5'b00010,
    PML_LVL_TWO   = 5'b00100,
    PML_LVL_THREE = 5'b01000,
    PML_LVL_BAD   = 5'b10000
  } pml_level_e;
  typedef logic [1:0] pml_sig_sel_t;
endpackage : pml_pkg

// *** rtl/pml_lock.sv ***
/*
  program memory lock logic: latches the three lock bits at reset release,
  decodes the protection level and gates code reads, programming, verify,
  external execution and data ram access; serves three signature bytes.
  assumes nonvolatile lock bits stable around reset and synchronous inputs.
*/
// Overview of operation
// - three signature bytes are readable by the programming system
// - no lock bit programmed: verify allowed, nothing protected
// - first bit: table reads from external code cannot fetch internal bytes
// - first bit programmed: further programming refused
// - first and second bits: level one limits plus verify disabled
// - all three bits: all lower limits plus no external execution
// - all three bits: internal data ram inaccessible
// - lock bit zero enables protection, one leaves it off
`timescale 1ns/10ps
`include "pml_regs.svh"
module pml_lock (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        protection_byte,
  input  wire logic              table_read_req,
  input  wire logic              table_read_from_ext,
  input  wire logic              program_req,
  input  wire logic              verify_req,
  input  wire logic              ext_fetch_req,
  input  wire logic              data_ram_req,
  input  wire pml_pkg::pml_sig_sel_t sig_sel,
  output logic [7:0]             sig_byte_q,
  output logic                   table_read_ok_q,
  output logic                   program_ok_q,
  output logic                   verify_ok_q,
  output logic                   ext_fetch_ok_q,
  output logic                   data_ram_ok_q,
  output pml_pkg::pml_level_e    level_q
);
  import pml_pkg::*;

  logic       capture_q;
  logic [2:0] lock_q;
  wire        lock_bit_first  = protection_byte[`PML_LOCK_FIRST_POS];
  wire        lock_bit_second = protection_byte[`PML_LOCK_SECOND_POS];
  wire        lock_bit_third  = protection_byte[`PML_LOCK_THIRD_POS];

  // catch one cycle after release; async reset may only load constants
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      capture_q <= 1'b1;
      lock_q    <= `PML_LOCK_RESET;
    end else if (capture_q) begin
      capture_q <= 1'b0;
      lock_q    <= {lock_bit_third, lock_bit_second, lock_bit_first};
    end
  end

  // zero bit means protected, one decoder per latched lock bit
  wire [2:0] prot;
  for (genvar g = 0; g < 3; g++) begin : g_prot
    assign prot[g] = (lock_q[g] == `PML_LOCK_ACTIVE);
  end
  wire       p1 = prot[0];
  wire       p2 = prot[1];
  wire       p3 = prot[2];
  pml_level_e level_d;
  // undefined patterns fall to the strongest level: fail closed
  assign level_d = (!p1 && !p2 && !p3) ? PML_LVL_NONE :
                   ( p1 && !p2 && !p3) ? PML_LVL_ONE  :
                   ( p1 &&  p2 && !p3) ? PML_LVL_TWO  :
                   ( p1 &&  p2 &&  p3) ? PML_LVL_THREE : PML_LVL_BAD;

  wire lvl_ge1 = (level_d != PML_LVL_NONE);
  wire lvl_ge2 = lvl_ge1 && (level_d != PML_LVL_ONE);
  wire lvl_ge3 = lvl_ge2 && (level_d != PML_LVL_TWO);
  // capture window also blocks: lock state unknown until latched
  wire guard   = capture_q;

  wire tr_ok_d  = table_read_req && !guard &&
                  !(lvl_ge1 && table_read_from_ext);
  wire pg_ok_d  = program_req && !guard && !lvl_ge1;
  wire vf_ok_d  = verify_req  && !guard && !lvl_ge2;
  wire ex_ok_d  = ext_fetch_req && !guard && !lvl_ge3;
  wire dr_ok_d  = data_ram_req && !guard && !lvl_ge3;
  wire [7:0] sig_d = (sig_sel == 2'h0) ? `PML_SIG_BYTE0 :
                     (sig_sel == 2'h1) ? `PML_SIG_BYTE1 :
                     (sig_sel == 2'h2) ? `PML_SIG_BYTE2 : 8'h00;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      table_read_ok_q <= 1'b0;
      program_ok_q    <= 1'b0;
      verify_ok_q     <= 1'b0;
      ext_fetch_ok_q  <= 1'b0;
      data_ram_ok_q   <= 1'b0;
      sig_byte_q      <= 8'h00;
      level_q         <= PML_LVL_NONE;
    end else begin
      table_read_ok_q <= tr_ok_d;
      program_ok_q    <= pg_ok_d;
      verify_ok_q     <= vf_ok_d;
      ext_fetch_ok_q  <= ex_ok_d;
      data_ram_ok_q   <= dr_ok_d;
      sig_byte_q      <= sig_d;
      level_q         <= level_d;
    end
  end

  property p_prog_blocked;
    @(posedge clock) disable iff (sys_rst)
      (lock_q[0] == 1'b0) |=> !program_ok_q;
  endproperty
  a_prog_blocked: assert property (p_prog_blocked)
    else $error("programming granted while locked");

  property p_tr_blocked;
    @(posedge clock) disable iff (sys_rst)
      (p1 && table_read_from_ext) |=> !table_read_ok_q;
  endproperty
  a_tr_blocked: assert property (p_tr_blocked)
    else $error("external table read of internal code");

  property p_verify_blocked;
    @(posedge clock) disable iff (sys_rst)
      (p1 && p2) |=> !verify_ok_q;
  endproperty
  a_verify_blocked: assert property (p_verify_blocked)
    else $error("verify granted at level two");

  property p_ext_blocked;
    @(posedge clock) disable iff (sys_rst)
      (p1 && p2 && p3) |=> !ext_fetch_ok_q;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked)
    else $error("external execution at level three");

  property p_ram_blocked;
    @(posedge clock) disable iff (sys_rst)
      (p1 && p2 && p3) |=> !data_ram_ok_q;
  endproperty
  a_ram_blocked: assert property (p_ram_blocked)
    else $error("data ram open at level three");

  property p_open_verify;
    @(posedge clock) disable iff (sys_rst)
      (!guard && level_d == PML_LVL_NONE && verify_req) |=> verify_ok_q;
  endproperty
  a_open_verify: assert property (p_open_verify)
    else $error("verify refused when unlocked");

  property p_lock_held;
    @(posedge clock) disable iff (sys_rst)
      !capture_q |=> $stable(lock_q);
  endproperty
  a_lock_held: assert property (p_lock_held)
    else $error("lock bits changed after capture");

  property p_sig;
    @(posedge clock) disable iff (sys_rst)
      (sig_sel == 2'h1) |=> (sig_byte_q == `PML_SIG_BYTE1);
  endproperty
  a_sig: assert property (p_sig)
    else $error("wrong signature byte");

  // release walk: one capture edge, then the latched level settles
  sequence s_capture;
    capture_q ##1 !capture_q;
  endsequence

  sequence s_settled;
    !capture_q ##1 !capture_q;
  endsequence

  property p_capture_once;
    @(posedge clock) disable iff (sys_rst)
      capture_q |=> !capture_q;
  endproperty
  a_capture_once: assert property (p_capture_once)
    else $error("lock capture lasted more than one cycle");

  // grants during capture would use a lock state not yet latched
  property p_capture_guard;
    @(posedge clock) disable iff (sys_rst)
      s_capture |-> (!table_read_ok_q && !program_ok_q && !verify_ok_q &&
                     !ext_fetch_ok_q && !data_ram_ok_q);
  endproperty
  a_capture_guard: assert property (p_capture_guard)
    else $error("grant issued during lock capture");

  // level output lags the latch by one cycle, so stability starts later
  property p_level_held;
    @(posedge clock) disable iff (sys_rst)
      s_settled |=> $stable(level_q);
  endproperty
  a_level_held: assert property (p_level_held)
    else $error("protection level moved after capture");

  property p_bad_closed;
    @(posedge clock) disable iff (sys_rst)
      (level_d == PML_LVL_BAD) |=> (!program_ok_q && !verify_ok_q &&
                                    !ext_fetch_ok_q && !data_ram_ok_q);
  endproperty
  a_bad_closed: assert property (p_bad_closed)
    else $error("undefined lock pattern left an access open");

  property p_internal_read;
    @(posedge clock) disable iff (sys_rst)
      (!guard && table_read_req && !table_read_from_ext) |=> table_read_ok_q;
  endproperty
  a_internal_read: assert property (p_internal_read)
    else $error("internal table read refused");

  property p_open_program;
    @(posedge clock) disable iff (sys_rst)
      (!guard && level_d == PML_LVL_NONE && program_req) |=> program_ok_q;
  endproperty
  a_open_program: assert property (p_open_program)
    else $error("programming refused when unlocked");

  property p_one_verify;
    @(posedge clock) disable iff (sys_rst)
      (!guard && level_d == PML_LVL_ONE && verify_req) |=> verify_ok_q;
  endproperty
  a_one_verify: assert property (p_one_verify)
    else $error("verify refused at level one");

  property p_ext_below_three;
    @(posedge clock) disable iff (sys_rst)
      (!guard && (level_d == PML_LVL_NONE || level_d == PML_LVL_ONE ||
                  level_d == PML_LVL_TWO) && ext_fetch_req) |=> ext_fetch_ok_q;
  endproperty
  a_ext_below_three: assert property (p_ext_below_three)
    else $error("external execution refused below level three");

  property p_ram_below_three;
    @(posedge clock) disable iff (sys_rst)
      (!guard && (level_d == PML_LVL_NONE || level_d == PML_LVL_ONE ||
                  level_d == PML_LVL_TWO) && data_ram_req) |=> data_ram_ok_q;
  endproperty
  a_ram_below_three: assert property (p_ram_below_three)
    else $error("data ram refused below level three");

  property p_sig_first;
    @(posedge clock) disable iff (sys_rst)
      (sig_sel == 2'h0) |=> (sig_byte_q == `PML_SIG_BYTE0);
  endproperty
  a_sig_first: assert property (p_sig_first)
    else $error("wrong first signature byte");

  property p_sig_last;
    @(posedge clock) disable iff (sys_rst)
      (sig_sel == 2'h2) |=> (sig_byte_q == `PML_SIG_BYTE2);
  endproperty
  a_sig_last: assert property (p_sig_last)
    else $error("wrong last signature byte");
endmodule : pml_lock

// *** verif/pml_prog_model.sv ***
/* image-side model: turns a lock level 0..3 into the lock byte, 4 = undefined.
   assumes the bench picks the level. */
`timescale 1ns/10ps
`include "pml_regs.svh"
module pml_prog_model (
  input  wire logic [2:0] lock_level,
  output logic      [7:0] protection_byte
);
  // one image byte; zero enables, so holes and spare bits read as ones
  function automatic logic [7:0] img_byte(input logic [15:0] addr, input logic [2:0] lv);
    logic [7:0] b;
    b = 8'hff;
    if (addr <= `PML_CODE_LAST_ADDR) begin
      b = addr[7:0] ^ addr[15:8];
    end else if (addr == `PML_LOCK_BYTE_ADDR) begin
      if (lv == 3'h4) begin
        b[`PML_LOCK_SECOND_POS] = `PML_LOCK_ACTIVE;
      end else begin
        b[`PML_LOCK_FIRST_POS]  = !(lv >= 3'h1);
        b[`PML_LOCK_SECOND_POS] = !(lv >= 3'h2);
        b[`PML_LOCK_THIRD_POS]  = !(lv >= 3'h3);
      end
    end
    return b;
  endfunction : img_byte

  always_comb begin
    protection_byte = img_byte(`PML_LOCK_BYTE_ADDR, lock_level);
  end
endmodule : pml_prog_model

// *** verif/test_program_memory_security_lock.sv ***
/* random and corner request traffic at every lock level, one reset each.
   assumes pml_lock with its image model in front. */
`timescale 1ns/10ps
`include "pml_regs.svh"
module test_program_memory_security_lock;
  import pml_pkg::*;
  logic         clock = 0;
  logic         sys_rst = 1;
  logic [2:0]   lock_level = 0;
  logic [7:0]   pbyte;
  logic [5:0]   req = 0;
  pml_sig_sel_t sel = 0;
  logic [7:0]   sig;
  logic [4:0]   ok;
  pml_level_e   lvl;
  int           n_mismatch = 0;
  int           n_tests = 0;
  initial forever #10 clock = ~clock;
  pml_prog_model u_img (.lock_level(lock_level), .protection_byte(pbyte));
  pml_lock u_dut (.clock(clock), .sys_rst(sys_rst), .protection_byte(pbyte),
    .table_read_req(req[0]), .table_read_from_ext(req[1]), .program_req(req[2]),
    .verify_req(req[3]), .ext_fetch_req(req[4]), .data_ram_req(req[5]), .sig_sel(sel),
    .sig_byte_q(sig), .table_read_ok_q(ok[4]), .program_ok_q(ok[3]), .verify_ok_q(ok[2]),
    .ext_fetch_ok_q(ok[1]), .data_ram_ok_q(ok[0]), .level_q(lvl));
  function automatic logic [17:0] expect_out(input int lv, input logic [5:0] r,
                                             input logic [1:0] s);
    logic [7:0] b;
    b = (s == 2'h0) ? `PML_SIG_BYTE0 : (s == 2'h1) ? `PML_SIG_BYTE1 :
        (s == 2'h2) ? `PML_SIG_BYTE2 : 8'h00;
    return {b, r[0] & (!r[1] | lv == 0), r[2] & lv == 0, r[3] & lv <= 1,
            r[4] & lv <= 2, r[5] & lv <= 2, 5'(1 << lv)};
  endfunction : expect_out
  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  task automatic run_level(input int lv);
    logic [17:0] exp;
    sys_rst = 1;
    req = 0;
    lock_level = 3'(lv);
    repeat (5) @(negedge clock);
    sys_rst = 0;
    @(negedge clock);
    // image changes after capture must not move the level
    lock_level = 3'(lv ^ 1);
    for (int i = 0; i < 24; i++) begin
      req = (i == 0) ? 6'h3f : (i == 1) ? 6'h3d : 6'($urandom);
      sel = (i < 4) ? 2'(i) : 2'($urandom);
      exp = expect_out(lv, req, sel);
      @(negedge clock);
      chk("signature", 18'(sig), 18'(exp[17:10]));
      chk("read prog", 18'(ok[4:3]), 18'(exp[9:8]));
      chk("vf ex ram", 18'(ok[2:0]), 18'(exp[7:5]));
      chk("level", 18'(lvl), 18'(exp[4:0]));
    end
    $display("test level %0d done", lv);
  endtask : run_level
  initial begin
    void'($urandom(32'ha0f2));
    for (int lv = 0; lv < 5; lv++) run_level(lv);
    give_verdict();
  end
  initial begin
    #10000;
    n_mismatch++;
    give_verdict();
  end
endmodule : test_program_memory_security_lock
